// ===== pcs_pkg.sv
// Shared constants and types for the frame-synchronised serial PCM port.
//
// Overview of operation
// RULE1 - Sync high: shift code out, MSB first
// RULE2 - Transmit last frame's sample, one frame latency
// RULE3 - Sync low: serial output back to high-Z
// RULE4 - Sample input about 4 us after sync
// RULE5 - Encode done within 18 slots of start
// RULE6 - Capture eight bits MSB first after sync
// RULE7 - Update output 28 sequencer clocks after slot
// RULE8 - Controller sends 8 kHz syncs, eight clocks wide
// RULE9 - Encode and decode sequencing use sequencer clock
// RULE10 - Controller supplies sequencer clock, tx-synchronous
// RULE11 - Bit clocks 64 kHz-2.048 MHz, mutually asynchronous
// RULE12 - Mu-law: sign plus magnitude code
// RULE13 - A-law: even bits of code inverted
// RULE14 - Ignore input and float output outside slots
package pcs_pkg;

  // --------------------
  // Code word layout
  // --------------------
  localparam int          CODE_W        = 8;          // Bits per PCM code
  localparam int          MAG_W         = 7;          // Magnitude field width
  localparam int          CNT_W         = 4;          // Bit counter width
  localparam logic [3:0]  BITS_PER_SLOT = 4'h8;       // Bits in one slot
  localparam logic [7:0]  ALAW_MASK     = 8'h55;      // Even-bit inversion
  localparam logic [7:0]  ZERO_CODE     = 8'h80;      // Idle code, sign+mag

  // --------------------
  // Sequencer timing
  // --------------------
  localparam int          SEQ_CLK_NS      = 488;      // Nominal sequencer period
  localparam int          SAMPLE_DELAY_NS = 4000;     // Sync rise to sampling
  localparam int          SAMPLE_TICKS_I  = SAMPLE_DELAY_NS / SEQ_CLK_NS;
  localparam logic [7:0]  SAMPLE_TICKS    =
    (SAMPLE_TICKS_I < 1) ? 8'h01 : 8'(SAMPLE_TICKS_I);
  localparam int          ENCODE_SLOTS    = 18;       // Longest encode, in slots
  localparam logic [7:0]  ENCODE_LIMIT    = 8'(ENCODE_SLOTS * 8);
  localparam logic [7:0]  CONVERT_TICKS   = ENCODE_LIMIT - SAMPLE_TICKS;
  localparam logic [7:0]  DECODE_TICKS    = 8'h1c;    // Slot end to update

  // --------------------
  // Types
  // --------------------
  typedef struct packed {
    logic             positive;                       // Sign, high = positive
    logic [MAG_W-1:0] magnitude;                      // Companded magnitude
  } pcs_sample_type;

  typedef enum logic [1:0] {
    ENC_IDLE,
    ENC_WAIT_SAMPLE,
    ENC_CONVERT
  } pcs_enc_state_type;

  typedef enum logic [0:0] {
    DEC_IDLE,
    DEC_WAIT
  } pcs_dec_state_type;

endpackage

// ===== pcs_sync.sv
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/10ps
module pcs_sync #(
  parameter int WIDTH = 1                             // Bits carried
) (
  input  wire logic             clk_in,               // Destination clock
  input  wire logic [WIDTH-1:0] async_in,             // Foreign levels
  output logic      [WIDTH-1:0] sync_out              // Safe copies
);

  // --------------------
  // Flop chain
  // --------------------
  logic [WIDTH-1:0] meta;                             // First stage, read only below
  logic [WIDTH-1:0] next_meta;                        // Next first stage
  logic [WIDTH-1:0] next_sync;                        // Next second stage

  // Next values: plain shift
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  // No reset: the chain flushes in two edges anyway
  always_ff @(posedge clk_in) begin
    meta     <= next_meta;
    sync_out <= next_sync;
  end

endmodule // pcs_sync

// ===== pcs_port.sv
// Serial PCM port: transmit shifter, receive capture, encode/decode sequencing.
`timescale 1ns/10ps
module pcs_port (
  input  wire logic                   ref_clk_in,       // Core clock, 200 MHz
  input  wire logic                   rst_in,           // Sync reset, high
  input  wire logic                   seq_clk_in,       // Sequencer clock pin
  input  wire logic                   alaw_select_in,   // High selects A-law
  input  wire pcs_pkg::pcs_sample_type sample_in,       // Converter sample
  input  wire logic                   tx_bit_clock_in,  // Transmit bit clock
  input  wire logic                   tx_frame_sync_in, // Transmit frame sync
  input  wire logic                   rx_bit_clock_in,  // Receive bit clock
  input  wire logic                   rx_frame_sync_in, // Receive frame sync
  input  wire logic                   pcm_data_in,      // Serial PCM input
  output logic                        pcm_data_out,     // Serial PCM output
  output logic                        pcm_data_oe_out,  // High while driving
  output pcs_pkg::pcs_sample_type     dac_code_out,     // Held decoded level
  output logic                        dac_update_out    // One-cycle update strobe
);

  // ------------------------------------------------------------------
  // Core-side synchronisers
  // ------------------------------------------------------------------
  localparam int CORE_SYNC_W = 12;                    // Pins plus rx toggle

  logic [CORE_SYNC_W-1:0] core_raw;                   // Foreign levels
  logic [CORE_SYNC_W-1:0] core_sync;                  // Synchronised levels
  logic                   rx_done_toggle;             // Rx domain event toggle
  logic                   seq_level;                  // Synced sequencer clock
  logic                   txs_level;                  // Synced tx frame sync
  logic                   rxt_level;                  // Synced rx toggle
  logic                   alaw;                       // Synced law select
  pcs_pkg::pcs_sample_type sample_sync;               // Synced sample

  assign core_raw = {seq_clk_in, tx_frame_sync_in, rx_done_toggle,
                     alaw_select_in, sample_in};

  pcs_sync #(.WIDTH(CORE_SYNC_W)) u_core_sync (
    .clk_in   (ref_clk_in),
    .async_in (core_raw),
    .sync_out (core_sync)
  );

  assign {seq_level, txs_level, rxt_level, alaw, sample_sync} = core_sync;

  // ------------------------------------------------------------------
  // Edge detection on synced levels
  // ------------------------------------------------------------------
  logic seq_prev;                                     // Last sequencer level
  logic txs_prev;                                     // Last tx sync level
  logic rxt_prev;                                     // Last rx toggle level
  logic seq_tick;                                     // Sequencer rising edge
  logic tx_frame_start;                               // Tx sync rising edge
  logic rx_slot_done;                                 // Rx slot finished

  // Edges derived only from the second flop stage
  always_comb begin
    seq_tick       = seq_level & ~seq_prev;           // [RULE9]
    tx_frame_start = txs_level & ~txs_prev;
    rx_slot_done   = rxt_level ^ rxt_prev;
  end

  // Previous levels, cleared by reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      seq_prev <= 1'b0;
      txs_prev <= 1'b0;
      rxt_prev <= 1'b0;
    end else begin
      seq_prev <= seq_level;
      txs_prev <= txs_level;
      rxt_prev <= rxt_level;
    end
  end

  // ------------------------------------------------------------------
  // Law formatting
  // ------------------------------------------------------------------
  // Same mask both ways, so one function serves encode and decode
  function automatic logic [7:0] law_format(input logic [7:0] code,
                                            input logic       use_alaw);
    law_format = use_alaw ? (code ^ pcs_pkg::ALAW_MASK) : code; // [RULE12] [RULE13]
  endfunction

  // ------------------------------------------------------------------
  // Encode sequencer
  // ------------------------------------------------------------------
  pcs_pkg::pcs_enc_state_type enc_state;              // Encoder state
  pcs_pkg::pcs_enc_state_type next_enc_state;
  logic [7:0]                 enc_cnt;                // Sequencer tick count
  logic [7:0]                 next_enc_cnt;
  pcs_pkg::pcs_sample_type    enc_sample;             // Held sample
  pcs_pkg::pcs_sample_type    next_enc_sample;
  logic [7:0]                 enc_code;               // Finished line code
  logic [7:0]                 next_enc_code;
  logic                       enc_toggle;             // Flips per finished code
  logic                       next_enc_toggle;

  // Sample after the delay, convert, then publish for the next frame
  always_comb begin
    next_enc_state  = enc_state;
    next_enc_cnt    = enc_cnt;
    next_enc_sample = enc_sample;
    next_enc_code   = enc_code;
    next_enc_toggle = enc_toggle;
    case (enc_state)
      pcs_pkg::ENC_IDLE: begin
        if (tx_frame_start) begin                     // Frame begins the count
          next_enc_state = pcs_pkg::ENC_WAIT_SAMPLE;
          next_enc_cnt   = 8'h00;
        end
      end
      pcs_pkg::ENC_WAIT_SAMPLE: begin
        if (seq_tick) begin
          if (enc_cnt == pcs_pkg::SAMPLE_TICKS - 8'h01) begin
            next_enc_sample = sample_sync;            // [RULE4]
            next_enc_state  = pcs_pkg::ENC_CONVERT;
            next_enc_cnt    = 8'h00;
          end else begin
            next_enc_cnt = enc_cnt + 8'h01;           // [RULE9]
          end
        end
      end
      pcs_pkg::ENC_CONVERT: begin
        if (seq_tick) begin
          if (enc_cnt == pcs_pkg::CONVERT_TICKS - 8'h01) begin
            // Ends inside the encode window, long before next slot
            next_enc_code   = law_format(enc_sample, alaw); // [RULE5]
            next_enc_toggle = ~enc_toggle;            // [RULE2]
            next_enc_state  = pcs_pkg::ENC_IDLE;
          end else begin
            next_enc_cnt = enc_cnt + 8'h01;
          end
        end
      end
      default: begin
        next_enc_state = pcs_pkg::ENC_IDLE;
      end
    endcase
  end

  // Encoder registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      enc_state  <= pcs_pkg::ENC_IDLE;
      enc_cnt    <= 8'h00;
      enc_sample <= pcs_pkg::ZERO_CODE;
      enc_code   <= pcs_pkg::ZERO_CODE;
      enc_toggle <= 1'b0;
    end else begin
      enc_state  <= next_enc_state;
      enc_cnt    <= next_enc_cnt;
      enc_sample <= next_enc_sample;
      enc_code   <= next_enc_code;
      enc_toggle <= next_enc_toggle;
    end
  end

  // ------------------------------------------------------------------
  // Decode sequencer
  // ------------------------------------------------------------------
  pcs_pkg::pcs_dec_state_type dec_state;              // Decoder state
  pcs_pkg::pcs_dec_state_type next_dec_state;
  logic [7:0]                 dec_cnt;                // Sequencer tick count
  logic [7:0]                 next_dec_cnt;
  logic [7:0]                 dec_word;               // Code taken from rx side
  logic [7:0]                 next_dec_word;
  logic [7:0]                 rx_word;                // Rx domain held word
  pcs_pkg::pcs_sample_type    next_dac_code;
  logic                       next_dac_update;

  // Rx word is stable from its toggle until the next slot ends
  always_comb begin
    next_dec_state  = dec_state;
    next_dec_cnt    = dec_cnt;
    next_dec_word   = dec_word;
    next_dac_code   = dac_code_out;
    next_dac_update = 1'b0;
    case (dec_state)
      pcs_pkg::DEC_IDLE: begin
        if (rx_slot_done) begin                       // Decode starts at slot end
          next_dec_word  = rx_word;
          next_dec_cnt   = 8'h00;
          next_dec_state = pcs_pkg::DEC_WAIT;
        end
      end
      pcs_pkg::DEC_WAIT: begin
        if (seq_tick) begin
          if (dec_cnt == pcs_pkg::DECODE_TICKS - 8'h01) begin
            next_dac_code   = law_format(dec_word, alaw); // [RULE7] [RULE13]
            next_dac_update = 1'b1;
            next_dec_state  = pcs_pkg::DEC_IDLE;
          end else begin
            next_dec_cnt = dec_cnt + 8'h01;           // [RULE9]
          end
        end
      end
      default: begin
        next_dec_state = pcs_pkg::DEC_IDLE;
      end
    endcase
  end

  // Decoder registers and held output level
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dec_state      <= pcs_pkg::DEC_IDLE;
      dec_cnt        <= 8'h00;
      dec_word       <= pcs_pkg::ZERO_CODE;
      dac_code_out   <= pcs_pkg::ZERO_CODE;
      dac_update_out <= 1'b0;
    end else begin
      dec_state      <= next_dec_state;
      dec_cnt        <= next_dec_cnt;
      dec_word       <= next_dec_word;
      dac_code_out   <= next_dac_code;
      dac_update_out <= next_dac_update;
    end
  end

  // ------------------------------------------------------------------
  // Transmit bit clock domain
  // ------------------------------------------------------------------
  // Sync and bit clock come from the same controller, so the sync is
  // already in this domain; only the reset, the toggle and the code it guards cross in.
  logic [1:0]            tx_sync_out;                 // Synced reset, toggle
  logic                  tx_rst;                      // Reset in tx domain
  logic                  tx_tog;                      // Synced encoder toggle
  logic                  tx_tog_prev;
  logic                  next_tx_tog_prev;
  logic [7:0]            tx_hold;                     // Next frame's code
  logic [7:0]            next_tx_hold;
  logic [7:0]            tx_shift;                    // Word being sent
  logic [7:0]            next_tx_shift;
  logic [pcs_pkg::CNT_W-1:0] tx_cnt;                  // Bits sent this slot
  logic [pcs_pkg::CNT_W-1:0] next_tx_cnt;
  logic                  next_pcm_data;
  logic                  next_pcm_oe;

  pcs_sync #(.WIDTH(2)) u_tx_sync (
    .clk_in   (tx_bit_clock_in),
    .async_in ({rst_in, enc_toggle}),
    .sync_out (tx_sync_out)
  );

  assign {tx_rst, tx_tog} = tx_sync_out;

  // Shift on each rising edge while the slot is open
  always_comb begin
    next_tx_tog_prev = tx_tog;
    next_tx_hold     = tx_hold;
    next_tx_shift    = tx_shift;
    next_tx_cnt      = tx_cnt;
    next_pcm_data    = pcm_data_out;
    next_pcm_oe      = pcm_data_oe_out;
    if (tx_tog != tx_tog_prev) begin
      next_tx_hold = enc_code;                        // [RULE2]
    end
    if (!tx_frame_sync_in) begin
      next_pcm_oe = 1'b0;                             // [RULE3] [RULE14]
      next_tx_cnt = '0;
    end else if (tx_cnt < pcs_pkg::BITS_PER_SLOT) begin
      if (tx_cnt == '0) begin
        next_pcm_data = tx_hold[pcs_pkg::CODE_W-1];   // [RULE1]
        next_tx_shift = {tx_hold[pcs_pkg::CODE_W-2:0], 1'b0};
      end else begin
        next_pcm_data = tx_shift[pcs_pkg::CODE_W-1];  // [RULE1]
        next_tx_shift = {tx_shift[pcs_pkg::CODE_W-2:0], 1'b0};
      end
      next_pcm_oe = 1'b1;
      next_tx_cnt = tx_cnt + 4'h1;
    end
  end

  // Transmit registers; the last bit stands until sync falls
  always_ff @(posedge tx_bit_clock_in) begin
    if (tx_rst) begin
      tx_tog_prev     <= 1'b0;
      tx_hold         <= pcs_pkg::ZERO_CODE;
      tx_shift        <= pcs_pkg::ZERO_CODE;
      tx_cnt          <= '0;
      pcm_data_out    <= 1'b0;
      pcm_data_oe_out <= 1'b0;
    end else begin
      tx_tog_prev     <= next_tx_tog_prev;
      tx_hold         <= next_tx_hold;
      tx_shift        <= next_tx_shift;
      tx_cnt          <= next_tx_cnt;
      pcm_data_out    <= next_pcm_data;
      pcm_data_oe_out <= next_pcm_oe;
    end
  end

  // ------------------------------------------------------------------
  // Receive bit clock domain
  // ------------------------------------------------------------------
  // Independent of the tx clock; only a toggle and a stable word leave.
  logic                      rx_rst;                  // Reset in rx domain
  logic [7:0]                rx_shift;                // Bits gathered so far
  logic [7:0]                next_rx_shift;
  logic [7:0]                next_rx_word;
  logic [pcs_pkg::CNT_W-1:0] rx_cnt;                  // Bits taken this slot
  logic [pcs_pkg::CNT_W-1:0] next_rx_cnt;
  logic                      next_rx_done_toggle;

  pcs_sync #(.WIDTH(1)) u_rx_sync (
    .clk_in   (rx_bit_clock_in),
    .async_in (rst_in),
    .sync_out (rx_rst)
  );

  // Capture first eight edges of the slot, ignore the rest
  always_comb begin
    next_rx_shift       = rx_shift;
    next_rx_word        = rx_word;
    next_rx_cnt         = rx_cnt;
    next_rx_done_toggle = rx_done_toggle;
    if (!rx_frame_sync_in) begin
      next_rx_cnt = '0;                               // [RULE14]
    end else if (rx_cnt < pcs_pkg::BITS_PER_SLOT) begin
      next_rx_shift = {rx_shift[pcs_pkg::CODE_W-2:0], pcm_data_in}; // [RULE6]
      next_rx_cnt   = rx_cnt + 4'h1;
      if (rx_cnt == pcs_pkg::BITS_PER_SLOT - 4'h1) begin
        next_rx_word        = {rx_shift[pcs_pkg::CODE_W-2:0], pcm_data_in};
        next_rx_done_toggle = ~rx_done_toggle;        // [RULE7] [RULE11]
      end
    end
  end

  // Receive registers
  always_ff @(posedge rx_bit_clock_in) begin
    if (rx_rst) begin
      rx_shift       <= pcs_pkg::ZERO_CODE;
      rx_word        <= pcs_pkg::ZERO_CODE;
      rx_cnt         <= '0;
      rx_done_toggle <= 1'b0;
    end else begin
      rx_shift       <= next_rx_shift;
      rx_word        <= next_rx_word;
      rx_cnt         <= next_rx_cnt;
      rx_done_toggle <= next_rx_done_toggle;
    end
  end

endmodule // pcs_port

// ===== pcs_port_assertions.sv
// Concurrent checks on the serial PCM port's link and decode timing.
`timescale 1ns/10ps
module pcs_port_assertions (
  input wire logic                    ref_clk_in,
  input wire logic                    rst_in,
  input wire logic                    seq_clk_in,
  input wire logic                    tx_bit_clock_in,
  input wire logic                    tx_frame_sync_in,
  input wire logic                    rx_frame_sync_in,
  input wire logic                    pcm_data_oe_out,
  input wire pcs_pkg::pcs_sample_type dac_code_out,
  input wire logic                    dac_update_out
);
  // --------------------
  // Helper counters
  // --------------------
  logic [2:0] seq_s;                          // Synced sequencer pin
  logic [1:0] rxs_s;                          // Synced rx sync
  logic [4:0] dec_ticks, next_dec_ticks;      // Ticks since rx slot end
  logic [4:0] sync_run, next_sync_run;        // Sync-high rises in a row
  logic [4:0] oe_run, next_oe_run;            // Driving rises in a row

  // Saturate so a long idle gap cannot wrap back into range
  always_comb begin
    next_dec_ticks = dec_ticks;
    if (rxs_s[1]) begin
      next_dec_ticks = 5'h00;
    end else if (seq_s[1] && !seq_s[2] && dec_ticks != 5'h1f) begin
      next_dec_ticks = dec_ticks + 5'h01;
    end
    next_sync_run = !tx_frame_sync_in ? 5'h00 : sync_run + 5'(sync_run != 5'h1f);
    next_oe_run   = !pcm_data_oe_out ? 5'h00 : oe_run + 5'(oe_run != 5'h1f);
  end

  // Same two-flop view of the pins as the design has
  always_ff @(posedge ref_clk_in) begin
    seq_s     <= {seq_s[1:0], seq_clk_in};
    rxs_s     <= {rxs_s[0], rx_frame_sync_in};
    dec_ticks <= next_dec_ticks;
  end

  always_ff @(posedge tx_bit_clock_in) begin
    sync_run <= next_sync_run;
    oe_run   <= next_oe_run;
  end

  // --------------------
  // Transmit link
  // --------------------
  chk_oe_sync_low: assert property (@(posedge tx_bit_clock_in) disable iff (rst_in)
    !tx_frame_sync_in |=> !pcm_data_oe_out) else $error("driven after sync low");
  chk_slot_start: assert property (@(posedge tx_bit_clock_in) disable iff (rst_in)
    tx_frame_sync_in && !pcm_data_oe_out |=> pcm_data_oe_out) else $error("slot did not start");
  chk_oe_cause: assert property (@(posedge tx_bit_clock_in) disable iff (rst_in)
    $rose(pcm_data_oe_out) |-> $past(tx_frame_sync_in)) else $error("drive without sync");
  chk_idle_float: assert property (@(posedge tx_bit_clock_in) disable iff (rst_in)
    !tx_frame_sync_in && !$past(tx_frame_sync_in) |-> !pcm_data_oe_out)
    else $error("driven outside slot");
  chk_bit_count: assert property (@(posedge tx_bit_clock_in) disable iff (rst_in)
    pcm_data_oe_out && sync_run <= 5'h08 |-> oe_run + 5'h01 == sync_run)
    else $error("driven bit count off");

  // --------------------
  // Decoder update
  // --------------------
  chk_update_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    dac_update_out |=> !dac_update_out) else $error("strobe too long");
  chk_code_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $changed(dac_code_out) |-> dac_update_out) else $error("code changed without update");
  chk_decode_delay: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    dac_update_out |-> dec_ticks >= 5'h1a && dec_ticks <= 5'h1d)
    else $error("update delay off");

  cover property (@(posedge ref_clk_in) disable iff (rst_in) dac_update_out);
  cover property (@(posedge tx_bit_clock_in) disable iff (rst_in) $rose(pcm_data_oe_out));
  cover property (@(posedge tx_bit_clock_in) disable iff (rst_in) $fell(pcm_data_oe_out));
endmodule // pcs_port_assertions

bind pcs_port pcs_port_assertions pcs_port_assertions_inst (
  .ref_clk_in, .rst_in, .seq_clk_in, .tx_bit_clock_in, .tx_frame_sync_in,
  .rx_frame_sync_in, .pcm_data_oe_out, .dac_code_out, .dac_update_out);

// ===== pcs_highway_model.sv
// Highway controller model: bit clocks, frame syncs, slot data in and out.
`timescale 1ns/10ps
module pcs_highway_model (
  input  wire logic       pcm_wire_in,     // Resolved serial output line
  input  wire logic [7:0] rx_word_in,      // Code for the next rx slot
  input  wire logic [3:0] rx_len_in,       // Rx sync width, bit clocks
  output logic            seq_clk_out,     // Tx clock divided by eight
  output logic            tx_clk_out,      // 64 ns transmit bit clock
  output logic            tx_sync_out,     // Transmit frame sync
  output logic            rx_clk_out,      // 72 ns, unrelated to tx
  output logic            rx_sync_out,     // Receive frame sync
  output logic            rx_data_out,     // Serial data to decoder
  output logic [7:0]      tx_word_out,     // Code seen in last tx slot
  output logic [3:0]      tx_bits_out,     // Bits seen driven in slot
  output int              tx_frames_out    // Tx frames started
);
  int         tx_cnt;                      // Position in tx frame
  int         rx_cnt;                      // Position in rx frame
  logic [2:0] seq_div;                     // Sequencer divider

  // Highway clocks run free; first syncs land after the reset
  initial begin
    tx_clk_out = 1'b0;
    rx_clk_out = 1'b0;
    tx_sync_out = 1'b0;
    rx_sync_out = 1'b0;
    rx_data_out = 1'b0;
    seq_div = 3'h0;
    tx_frames_out = 0;
    tx_cnt = 1933;
    rx_cnt = 1618;
    #11;
    forever #36 rx_clk_out = ~rx_clk_out;  // Asynchronous rx clock
  end
  always #32 tx_clk_out = ~tx_clk_out;
  always @(posedge tx_clk_out) seq_div <= seq_div + 3'h1;
  assign seq_clk_out = seq_div[2];         // 1.95 MHz, locked to tx

  // Syncs move on falling edges, clear of the sampling rise
  always @(negedge tx_clk_out) begin
    if (tx_cnt < 8 && (pcm_wire_in === 1'b0 || pcm_wire_in === 1'b1)) begin
      tx_word_out <= {tx_word_out[6:0], pcm_wire_in};
      tx_bits_out <= tx_bits_out + 4'h1;
    end
    if (tx_cnt == 1952) begin
      tx_bits_out <= 4'h0;
      tx_frames_out <= tx_frames_out + 1;
    end
    tx_sync_out <= tx_cnt == 1952 || tx_cnt < 7;  // 8 kHz, eight clocks
    tx_cnt <= (tx_cnt == 1952) ? 0 : tx_cnt + 1;
  end

  // Toggle beyond bit eight so stale data never passes
  always @(negedge rx_clk_out) begin : rx_side
    int n;
    n = (rx_cnt == 1735) ? 0 : rx_cnt + 1;
    rx_sync_out <= n < int'(rx_len_in);
    rx_data_out <= (n < 8) ? rx_word_in[3'(7 - n)] : ~rx_data_out;
    rx_cnt <= n;
  end
endmodule // pcs_highway_model

// ===== pcs_port_tb.sv
// Self-checking bench for the serial PCM port.
`timescale 1ns/10ps
module pcs_port_tb;
  logic                    ref_clk = 1'b0;       // 200 MHz core clock
  logic                    rst = 1'b1;           // Synchronous reset
  logic                    alaw_sel = 1'b0;      // Law select
  pcs_pkg::pcs_sample_type sample = '0;          // Converter stand-in
  logic [7:0]              rx_word = 8'h00;      // Next rx slot code
  logic [3:0]              rx_len = 4'h8;        // Next rx sync width
  logic                    pcm_out, pcm_oe, dac_update;
  pcs_pkg::pcs_sample_type dac_code;
  logic                    seq_clk, tx_clk, tx_sync, rx_clk, rx_sync, rx_data;
  logic [7:0]              tx_word;
  logic [3:0]              tx_bits;
  int                      tx_frames;
  int                      mismatches = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  wire                     pcm_wire = pcm_oe ? pcm_out : 1'bz;  // Three-state line

  always #2.5 ref_clk = ~ref_clk;

  pcs_port pcs_port_inst (.ref_clk_in(ref_clk), .rst_in(rst), .seq_clk_in(seq_clk),
    .alaw_select_in(alaw_sel), .sample_in(sample), .tx_bit_clock_in(tx_clk),
    .tx_frame_sync_in(tx_sync), .rx_bit_clock_in(rx_clk), .rx_frame_sync_in(rx_sync),
    .pcm_data_in(rx_data), .pcm_data_out(pcm_out), .pcm_data_oe_out(pcm_oe),
    .dac_code_out(dac_code), .dac_update_out(dac_update));

  pcs_highway_model pcs_highway_model_inst (.pcm_wire_in(pcm_wire), .rx_word_in(rx_word),
    .rx_len_in(rx_len), .seq_clk_out(seq_clk), .tx_clk_out(tx_clk), .tx_sync_out(tx_sync),
    .rx_clk_out(rx_clk), .rx_sync_out(rx_sync), .rx_data_out(rx_data),
    .tx_word_out(tx_word), .tx_bits_out(tx_bits), .tx_frames_out(tx_frames));

  // --------------------
  // Shared tasks
  // --------------------
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sample valid 2..6 us after sync rise; a mistimed capture sees the decoy
  task automatic run_frame(input pcs_pkg::pcs_sample_type s, input logic law,
      input logic [7:0] rxw, input logic [3:0] len, input logic [7:0] exp_tx,
      input logic [7:0] exp_dac, input bit do_rx);
    int f;
    f = tx_frames;
    wait (tx_frames != f);
    @(posedge ref_clk);
    rx_word <= rxw;
    rx_len <= len;
    repeat (400) @(posedge ref_clk);
    sample <= s;
    alaw_sel <= law;
    check8(tx_word, exp_tx);
    check8({4'h0, tx_bits}, 8'h08);
    repeat (800) @(posedge ref_clk);
    sample <= pcs_pkg::pcs_sample_type'(~s);
    if (do_rx) begin
      for (int i = 0; i < 8000 && dac_update !== 1'b1; i++) @(negedge ref_clk);
      check8({7'h00, dac_update}, 8'h01);
      check8(dac_code, exp_dac);
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic test_reset_idle();
    @(negedge ref_clk);
    check8(dac_code, pcs_pkg::ZERO_CODE);
    check8({7'h00, dac_update}, 8'h00);
    check8({7'h00, pcm_oe}, 8'h00);
  endtask

  // Mu-law negative full scale received, reset code sent
  task automatic test_first_frame();
    run_frame('{1'b1, 7'h7f}, 1'b0, 8'h7f, 4'h8, pcs_pkg::ZERO_CODE, 8'h7f, 1'b1);
  endtask

  // Wide rx sync with junk after bit eight; A-law full scale decoded
  task automatic test_mu_to_alaw();
    run_frame('{1'b0, 7'h7f}, 1'b1, 8'haa, 4'ha, 8'hff, 8'hff, 1'b1);
  endtask

  // A-law negative full scale sent, A-law zero decoded
  task automatic test_alaw_zero();
    run_frame('{1'b1, 7'h00}, 1'b1, 8'hd5, 4'h8, 8'h2a, 8'h80, 1'b1);
  endtask

  // A-law zero code sent one frame after its sample
  task automatic test_alaw_idle_out();
    run_frame('{1'b0, 7'h00}, 1'b0, 8'h00, 4'h8, 8'hd5, 8'h00, 1'b0);
  endtask

  // Hang guard: four frames need about 76500 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      final_report();
    end
  end

  // Reset long enough to cross into both bit-clock domains
  initial begin
    repeat (60) @(posedge ref_clk);
    test_reset_idle();
    @(posedge ref_clk);
    rst <= 1'b0;
    test_first_frame();
    test_mu_to_alaw();
    test_alaw_zero();
    test_alaw_idle_out();
    final_report();
  end
endmodule // pcs_port_tb
